// [rtl/lic_map.vh]
`ifndef LIC_MAP_VH
`define LIC_MAP_VH
// Byte I/O ports of the controller pair and the trigger selects
`define LIC_MASTER_BASE 16'h0020
`define LIC_SLAVE_BASE 16'h00a0
`define LIC_ODD_OFS 16'h0001
`define LIC_TRIG_LO_ADDR 16'h04d0
`define LIC_TRIG_HI_ADDR 16'h04d1
// Writable bits of the trigger selects; reserved bits stay zero
`define LIC_TRIG_LO_WMASK 8'hfa
`define LIC_TRIG_HI_WMASK 8'hde
// Even- and odd-port write field positions
`define LIC_INIT_BIT 4
`define LIC_LEVEL_BIT 3
`define LIC_SEL_HI 4
`define LIC_SEL_LO 3
`define LIC_SEL_ROTATE 2'h0
`define LIC_SEL_SPECIAL 2'h1
`define LIC_CODE_HI 7
`define LIC_CODE_LO 5
`define LIC_LINE_HI 2
`define LIC_LINE_LO 0
`define LIC_SMASK_HI 6
`define LIC_SMASK_LO 5
`define LIC_RDSEL_HI 1
`define LIC_RDSEL_LO 0
`define LIC_VBASE_HI 7
`define LIC_VBASE_LO 3
`define LIC_AUTO_EOS_BIT 1
// Rotate and end-of-service command codes
`define LIC_CMD_ROT_OFF 3'h0
`define LIC_CMD_NS_EOS 3'h1
`define LIC_CMD_NOP 3'h2
`define LIC_CMD_SP_EOS 3'h3
`define LIC_CMD_ROT_ON 3'h4
`define LIC_CMD_ROT_NS 3'h5
`define LIC_CMD_SET_PRIO 3'h6
`define LIC_CMD_ROT_SP 3'h7
// Special-mask field and register-read field values
`define LIC_SMASK_CLR 2'h2
`define LIC_SMASK_SET 2'h3
`define LIC_RD_PENDING 2'h2
`define LIC_RD_INSVC 2'h3
// Reset values and fixed lines
`define LIC_RST_BYTE 8'h00
`define LIC_RST_LOWEST 3'h7
`define LIC_CASCADE_LINE 3'h2
`define LIC_SPURIOUS_LINE 3'h7
`endif

// [rtl/lic_prio.v]
`timescale 1ns/1ps
`default_nettype none
`include "lic_map.vh"
// Finds the highest-priority set bit; priority starts just above lowest_i
module lic_prio
(
    input wire [7:0] req_i, // Candidate lines
    input wire [2:0] lowest_i, // Line holding the lowest priority
    output reg found_o, // Some candidate is set
    output reg [2:0] idx_o // Winning line, spurious line when none
);
    integer k;
    reg [2:0] pos;

    // Scan from lowest priority upward so the last hit is the best one
    always @*
    begin
        found_o = 1'b0;
        idx_o = `LIC_SPURIOUS_LINE;
        pos = 3'h0;
        for (k = 7; k >= 0; k = k - 1)
        begin
            pos = lowest_i + 3'h1 + k[2:0];
            if (req_i[pos])
            begin
                found_o = 1'b1;
                idx_o = pos;
            end
        end
    end
endmodule // lic_prio
`default_nettype wire

// [rtl/lic_top.v]
// Behaviour
// - Even write, selector 00: decode rotate command code
// - 001 clears top in-service; 011 clears named line
// - 101 and 111 end service and rotate priority
// - 100 enables, 000 disables auto-service rotation
// - 110 sets priority from named line; 010 idles
// - Even write, selector 01: special command word
// - Special-mask field: 0x keep, 10 clear, 11 set
// - Special mask on: mask and in-service bits block requests
// - Special mask off: need higher than in-service
// - Acknowledge picks highest priority allowed request
// - Read field 10 pending, 11 in-service, else none
// - Pending image bit per line, 0 means pending
// - In-service image bit per line, 1 active
// - Low trigger select: lines 1, 3 to 7
// - High trigger select: lines 9-12, 14, 15
// - Controller level bit overrides per-line select
// - Even write with bit 4 starts initialization
// - Three odd writes then back to operation
// - Mask bit 1 blocks its line
// - Master lines 0-7, line 2 cascades slave
`timescale 1ns/1ps
`default_nettype none
`include "lic_map.vh"
module lic_top
(
    input wire clk_i, // System clock, 10 MHz
    input wire rstn_i, // Synchronous reset, active low
    input wire [15:0] io_addr_i, // I/O byte address
    input wire io_wr_i, // I/O write strobe, one cycle
    input wire io_rd_i, // I/O read strobe, one cycle
    input wire [7:0] io_wdata_i, // I/O write data
    output reg [7:0] io_rdata_o, // Read data, valid cycle after strobe
    input wire [15:0] irq_i, // Request pins; bit 2 is unused
    input wire inta_i, // Interrupt acknowledge, one cycle
    output reg intr_o, // Interrupt request to the CPU
    output reg [7:0] vector_o, // Vector of the last acknowledge
    output reg vector_valid_o // Vector strobe, one cycle
);
    // Initialization steps
    localparam [1:0] ST_OPER = 2'h0;
    localparam [1:0] ST_VBASE = 2'h1;
    localparam [1:0] ST_CASC = 2'h2;
    localparam [1:0] ST_MODE = 2'h3;

    reg [15:0] irq_m_q; // First synchroniser stage
    reg [15:0] irq_s_q; // Second synchroniser stage
    reg [7:0] trig_lo_q; // Low trigger select
    reg [7:0] trig_hi_q; // High trigger select
    wire [1:0] intr_w; // Each controller's request output
    wire [1:0] found_w; // Each controller has a winner
    wire [5:0] win_w; // Winning line per controller
    wire [1:0] ack_w; // Acknowledge reaching each controller
    wire [9:0] vbase_w; // Vector base per controller
    wire [15:0] rd_even_w; // Even-port read image per controller
    wire [15:0] mask_w; // Mask per controller
    wire [15:0] line_w; // Request level seen by each line

    // Pins are asynchronous, so two flops before any use
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            irq_m_q <= 16'h0000;
            irq_s_q <= 16'h0000;
        end
        else
        begin
            irq_m_q <= irq_i;
            irq_s_q <= irq_m_q;
        end
    end

    // Master line 2 carries the slave's request, not a pin
    assign line_w = {irq_s_q[15:8], irq_s_q[7:3], intr_w[1], irq_s_q[1:0]};

    // The slave answers only when the master picks the cascade line
    assign ack_w[0] = inta_i;
    assign ack_w[1] = inta_i && found_w[0] && (win_w[2:0] == `LIC_CASCADE_LINE);

    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1)
        begin : g_ctl
            localparam [15:0] BASE = (c == 0) ? `LIC_MASTER_BASE : `LIC_SLAVE_BASE;
            reg [1:0] step_q; // Initialization step
            reg level_all_q; // Controller-wide level trigger
            reg [4:0] vbase_q; // Vector base
            reg auto_eos_q; // Automatic end-of-service mode
            reg rot_auto_q; // Rotate on automatic end of service
            reg smm_q; // Special-mask flag
            reg rdsel_q; // Even read shows in-service when set
            reg [2:0] lowest_q; // Lowest-priority line
            reg [7:0] mask_q; // Mask word
            reg [7:0] pend_q; // Pending requests, 1 is pending
            reg [7:0] insvc_q; // Lines in service
            reg [7:0] line_q; // Last line level, for edges
            reg [7:0] pend_d;
            reg [7:0] insvc_d;
            reg [7:0] higher; // Lines above the top in-service line
            reg [7:0] cand; // Requests allowed to reach the CPU
            reg [2:0] rk;
            reg [2:0] rk_top;
            integer i;
            wire [7:0] line = line_w[c*8 +: 8];
            wire [7:0] sel = (c == 0) ? trig_lo_q : trig_hi_q;
            // Per-line select, global level override, cascade line always level
            wire [7:0] lvl = {8{level_all_q}} | sel
                | ((c == 0) ? 8'h04 : 8'h00);
            wire wr_even = io_wr_i && (io_addr_i == BASE);
            wire wr_odd = io_wr_i && (io_addr_i == (BASE + `LIC_ODD_OFS));
            wire [1:0] wsel = io_wdata_i[`LIC_SEL_HI:`LIC_SEL_LO];
            wire [2:0] wline = io_wdata_i[`LIC_LINE_HI:`LIC_LINE_LO];
            wire is_found;
            wire [2:0] is_idx;
            wire ack = ack_w[c] && found_w[c];
            wire [2:0] win = win_w[c*3 +: 3];

            // Highest-priority line in service
            lic_prio u_isv
            (
                .req_i(insvc_q),
                .lowest_i(lowest_q),
                .found_o(is_found),
                .idx_o(is_idx)
            );

            // Highest-priority allowed request
            lic_prio u_req
            (
                .req_i(cand),
                .lowest_i(lowest_q),
                .found_o(found_w[c]),
                .idx_o(win_w[c*3 +: 3])
            );

            // Which requests may reach the CPU
            always @*
            begin
                rk_top = is_idx - lowest_q - 3'h1;
                rk = 3'h0;
                for (i = 0; i < 8; i = i + 1)
                begin
                    rk = i[2:0] - lowest_q - 3'h1;
                    higher[i] = !is_found || (rk < rk_top);
                end
                if (smm_q)
                    cand = pend_q & ~mask_q & ~insvc_q;
                else
                    cand = pend_q & ~mask_q & higher;
            end

            // Next pending and in-service images
            always @*
            begin
                pend_d = pend_q & ~lvl;
                if (ack)
                    pend_d[win] = 1'b0;
                // A new edge in the acknowledge cycle is kept
                pend_d = pend_d | (line & ~line_q & ~lvl) | (line & lvl);
                insvc_d = insvc_q;
                // End-of-service commands are ignored while an initialization sequence is in progress
                if (wr_even && step_q == ST_OPER && !io_wdata_i[`LIC_INIT_BIT]
                    && wsel == `LIC_SEL_ROTATE)
                begin
                    case (io_wdata_i[`LIC_CODE_HI:`LIC_CODE_LO])
                        `LIC_CMD_NS_EOS, `LIC_CMD_ROT_NS:
                            insvc_d[is_idx] = insvc_q[is_idx] & ~is_found;
                        `LIC_CMD_SP_EOS, `LIC_CMD_ROT_SP:
                            insvc_d[wline] = 1'b0;
                        default:
                            insvc_d = insvc_q;
                    endcase
                end
                if (ack && !auto_eos_q)
                    insvc_d[win] = 1'b1;
            end

            // Command decode and controller state
            always @(posedge clk_i)
            begin
                if (!rstn_i)
                begin
                    step_q <= ST_OPER;
                    level_all_q <= 1'b0;
                    vbase_q <= 5'h00;
                    auto_eos_q <= 1'b0;
                    rot_auto_q <= 1'b0;
                    smm_q <= 1'b0;
                    rdsel_q <= 1'b0;
                    lowest_q <= `LIC_RST_LOWEST;
                    mask_q <= `LIC_RST_BYTE;
                    pend_q <= `LIC_RST_BYTE;
                    insvc_q <= `LIC_RST_BYTE;
                    line_q <= `LIC_RST_BYTE;
                end
                else
                begin
                    line_q <= line;
                    pend_q <= pend_d;
                    insvc_q <= insvc_d;
                    // Auto service with rotation makes the winner lowest
                    if (ack && auto_eos_q && rot_auto_q)
                        lowest_q <= win;
                    if (wr_even && io_wdata_i[`LIC_INIT_BIT])
                    begin
                        // Start of initialization resets mask, in-service, special mask, read select, rotation and priority; pending, vector base and auto end-of-service are kept
                        step_q <= ST_VBASE;
                        level_all_q <= io_wdata_i[`LIC_LEVEL_BIT];
                        smm_q <= 1'b0;
                        mask_q <= `LIC_RST_BYTE;
                        insvc_q <= `LIC_RST_BYTE;
                        rdsel_q <= 1'b0;
                        rot_auto_q <= 1'b0;
                        lowest_q <= `LIC_RST_LOWEST;
                    end
                    else if (wr_odd)
                    begin
                        case (step_q)
                            ST_VBASE:
                            begin
                                vbase_q <= io_wdata_i[`LIC_VBASE_HI:`LIC_VBASE_LO];
                                step_q <= ST_CASC;
                            end
                            ST_CASC:
                                step_q <= ST_MODE;
                            ST_MODE:
                            begin
                                auto_eos_q <= io_wdata_i[`LIC_AUTO_EOS_BIT];
                                step_q <= ST_OPER;
                            end
                            default:
                                mask_q <= io_wdata_i;
                        endcase
                    end
                    else if (wr_even && step_q == ST_OPER && wsel == `LIC_SEL_ROTATE)
                    begin
                        case (io_wdata_i[`LIC_CODE_HI:`LIC_CODE_LO])
                            `LIC_CMD_ROT_OFF:
                                rot_auto_q <= 1'b0;
                            `LIC_CMD_ROT_ON:
                                rot_auto_q <= 1'b1;
                            `LIC_CMD_ROT_NS:
                                if (is_found)
                                    lowest_q <= is_idx;
                            `LIC_CMD_ROT_SP, `LIC_CMD_SET_PRIO:
                                lowest_q <= wline;
                            default:
                                lowest_q <= lowest_q;
                        endcase
                    end
                    else if (wr_even && step_q == ST_OPER && wsel == `LIC_SEL_SPECIAL)
                    begin
                        // Special command word; bit 2 poll is not honoured
                        if (io_wdata_i[`LIC_SMASK_HI:`LIC_SMASK_LO] == `LIC_SMASK_CLR)
                            smm_q <= 1'b0;
                        else if (io_wdata_i[`LIC_SMASK_HI:`LIC_SMASK_LO] == `LIC_SMASK_SET)
                            smm_q <= 1'b1;
                        if (io_wdata_i[`LIC_RDSEL_HI:`LIC_RDSEL_LO] == `LIC_RD_PENDING)
                            rdsel_q <= 1'b0;
                        else if (io_wdata_i[`LIC_RDSEL_HI:`LIC_RDSEL_LO] == `LIC_RD_INSVC)
                            rdsel_q <= 1'b1;
                    end
                end
            end

            assign intr_w[c] = found_w[c];
            assign vbase_w[c*5 +: 5] = vbase_q;
            assign mask_w[c*8 +: 8] = mask_q;
            // Pending image reads 0 for a pending line
            assign rd_even_w[c*8 +: 8] = rdsel_q ? insvc_q : ~pend_q;
        end
    endgenerate

    // Trigger selects, reserved bits held at zero
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            trig_lo_q <= `LIC_RST_BYTE;
            trig_hi_q <= `LIC_RST_BYTE;
        end
        else if (io_wr_i && io_addr_i == `LIC_TRIG_LO_ADDR)
            trig_lo_q <= io_wdata_i & `LIC_TRIG_LO_WMASK;
        else if (io_wr_i && io_addr_i == `LIC_TRIG_HI_ADDR)
            trig_hi_q <= io_wdata_i & `LIC_TRIG_HI_WMASK;
    end

    // Registered read data; unmapped reads return zero
    always @(posedge clk_i)
    begin
        if (!rstn_i)
            io_rdata_o <= `LIC_RST_BYTE;
        else if (!io_rd_i)
            io_rdata_o <= io_rdata_o;
        else if (io_addr_i == `LIC_MASTER_BASE)
            io_rdata_o <= rd_even_w[7:0];
        else if (io_addr_i == `LIC_MASTER_BASE + `LIC_ODD_OFS)
            io_rdata_o <= mask_w[7:0];
        else if (io_addr_i == `LIC_SLAVE_BASE)
            io_rdata_o <= rd_even_w[15:8];
        else if (io_addr_i == `LIC_SLAVE_BASE + `LIC_ODD_OFS)
            io_rdata_o <= mask_w[15:8];
        else if (io_addr_i == `LIC_TRIG_LO_ADDR)
            io_rdata_o <= trig_lo_q;
        else if (io_addr_i == `LIC_TRIG_HI_ADDR)
            io_rdata_o <= trig_hi_q;
        else
            io_rdata_o <= `LIC_RST_BYTE;
    end

    // Request output and vector delivery
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            intr_o <= 1'b0;
            vector_o <= `LIC_RST_BYTE;
            vector_valid_o <= 1'b0;
        end
        else
        begin
            intr_o <= intr_w[0];
            vector_valid_o <= inta_i;
            if (ack_w[1])
                vector_o <= {vbase_w[9:5], win_w[5:3]};
            else if (inta_i)
                vector_o <= {vbase_w[4:0], win_w[2:0]};
        end
    end
endmodule // lic_top
`default_nettype wire

// [testbench/lic_top_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lic_map.vh"
// Port-level checks of the controller pair
module lic_top_chk
(
    input wire logic clk_i, // System clock
    input wire logic rstn_i, // Reset, active low
    input wire logic [15:0] io_addr_i, // Byte address
    input wire logic io_wr_i, // Write strobe
    input wire logic io_rd_i, // Read strobe
    input wire logic [7:0] io_wdata_i, // Write data
    input wire logic [7:0] io_rdata_o, // Read data
    input wire logic [15:0] irq_i, // Request pins
    input wire logic inta_i, // Acknowledge
    input wire logic intr_o, // Request to CPU
    input wire logic [7:0] vector_o, // Vector
    input wire logic vector_valid_o // Vector strobe
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic [7:0] lo_q; // Expected low trigger select
    logic [7:0] hi_q; // Expected high trigger select
    logic mapped; // Address hits a decoded port
    assign mapped = io_addr_i == 16'h0020 || io_addr_i == 16'h0021 || io_addr_i == 16'h00a0
        || io_addr_i == 16'h00a1 || io_addr_i == `LIC_TRIG_LO_ADDR || io_addr_i == `LIC_TRIG_HI_ADDR;
    // Shadow copies keep only the writable bits, so reserved bits must read zero
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            lo_q <= 8'h00;
            hi_q <= 8'h00;
        end
        else if (io_wr_i && io_addr_i == `LIC_TRIG_LO_ADDR)
            lo_q <= io_wdata_i & `LIC_TRIG_LO_WMASK;
        else if (io_wr_i && io_addr_i == `LIC_TRIG_HI_ADDR)
            hi_q <= io_wdata_i & `LIC_TRIG_HI_WMASK;
    end
    ack_valid_pulse_a: assert property (inta_i |=> vector_valid_o)
        else $error("no vector strobe after acknowledge");
    valid_cause_a: assert property (vector_valid_o |-> $past(inta_i))
        else $error("vector strobe without acknowledge");
    vector_hold_a: assert property (!vector_valid_o |-> $stable(vector_o))
        else $error("vector changed without strobe");
    rdata_hold_a: assert property (!$past(io_rd_i) |-> $stable(io_rdata_o))
        else $error("read data changed without read");
    unmapped_zero_a: assert property (io_rd_i && !mapped |=> io_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    trig_lo_echo_a: assert property (io_rd_i && io_addr_i == `LIC_TRIG_LO_ADDR |=> io_rdata_o == lo_q)
        else $error("low trigger select readback wrong");
    trig_hi_echo_a: assert property (io_rd_i && io_addr_i == `LIC_TRIG_HI_ADDR |=> io_rdata_o == hi_q)
        else $error("high trigger select readback wrong");
    trig_rsvd_a: assert property (io_rd_i && io_addr_i == `LIC_TRIG_HI_ADDR |=> !io_rdata_o[5] && !io_rdata_o[0])
        else $error("reserved trigger bit set");
    first_quiet_a: assert property ($rose(rstn_i) |-> !intr_o && !vector_valid_o && io_rdata_o == 8'h00)
        else $error("outputs active after reset");
    cover property (vector_valid_o && vector_o == 8'h72);
    cover property ($rose(intr_o));
    cover property (io_rd_i && io_addr_i == `LIC_TRIG_HI_ADDR);
endmodule // lic_top_chk
bind lic_top lic_top_chk lic_top_chk_i
(
    .clk_i(clk_i), .rstn_i(rstn_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .irq_i(irq_i),
    .inta_i(inta_i), .intr_o(intr_o), .vector_o(vector_o), .vector_valid_o(vector_valid_o)
);
`default_nettype wire

// [testbench/lic_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Host CPU model: byte I/O cycles and interrupt acknowledges
module lic_host
(
    input wire logic clk_i, // System clock
    input wire logic [7:0] io_rdata_i, // Read data
    input wire logic [7:0] vector_i, // Acknowledge vector
    input wire logic vector_valid_i, // Vector strobe
    output var logic [15:0] io_addr_o, // Byte address
    output var logic io_wr_o, // Write strobe
    output var logic io_rd_o, // Read strobe
    output var logic [7:0] io_wdata_o, // Write data
    output var logic inta_o // Acknowledge pulse
);
    // Idle bus at time zero
    initial
    begin
        io_addr_o = 16'hffff;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
        inta_o = 1'b0;
    end
    // One-cycle strobe; released bus shows inverted values, not the stale ones
    task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_i);
        #1;
        io_addr_o = a;
        io_wdata_o = d;
        io_wr_o = w;
        io_rd_o = !w;
        @(posedge clk_i);
        #1;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_addr_o = ~a;
        io_wdata_o = ~d;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(a, d, 1'b1);
    endtask
    // Read data is registered, so it is settled one edge after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        cyc(a, 8'h00, 1'b0);
        d = io_rdata_i;
    endtask
    task automatic ack(output logic [7:0] v, output logic vv);
        @(posedge clk_i);
        #1;
        inta_o = 1'b1;
        @(posedge clk_i);
        #1;
        inta_o = 1'b0;
        v = vector_i;
        vv = vector_valid_i;
    endtask
    // First word, then vector base, cascade and mode back to back
    task automatic init(input logic [15:0] b, input logic [7:0] w1, input logic [7:0] vb,
        input logic [7:0] cs, input logic [7:0] md);
        wr(b, w1);
        wr(b | 16'h0001, vb);
        wr(b | 16'h0001, cs);
        wr(b | 16'h0001, md);
    endtask
endmodule // lic_host
`default_nettype wire

// [testbench/lic_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module lic_top_tb_top;
    logic clk_i = 1'b0; // 10 MHz clock
    logic rstn_i = 1'b0; // Reset, active low
    logic [15:0] irq_i = 16'h0000; // Request pins
    wire logic [15:0] io_addr; // Host address
    wire logic io_wr, io_rd, inta, intr, vvalid; // Strobes and flags
    wire logic [7:0] io_wdata, io_rdata, vector; // Data paths
    int n_mismatch = 0; // Failed compares
    int samples_checked = 0; // All compares
    always #50 clk_i = ~clk_i;
    lic_top lic_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
        .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .irq_i(irq_i),
        .inta_i(inta), .intr_o(intr), .vector_o(vector), .vector_valid_o(vvalid));
    lic_host lic_host_i (.clk_i(clk_i), .io_rdata_i(io_rdata), .vector_i(vector),
        .vector_valid_i(vvalid), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
        .io_wdata_o(io_wdata), .inta_o(inta));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    // Pins change, then six edges pass so sync and pending flops settle
    task automatic pins(input logic [15:0] v);
        @(posedge clk_i);
        #1;
        irq_i = v;
        repeat (6) @(posedge clk_i);
        #1;
    endtask
    // Write a port then read it back; selects images at the even ports
    task automatic img(input logic [15:0] a, input logic [7:0] w, input logic [7:0] exp);
        logic [7:0] d;
        lic_host_i.wr(a, w);
        lic_host_i.rd(a, d);
        chk8(d, exp);
    endtask
    // Bounded wait for the request, then acknowledge and check the vector
    task automatic serve(input logic [7:0] exp);
        int k;
        logic [7:0] v;
        logic vv;
        k = 0;
        while (intr !== 1'b1 && k < 40)
        begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk1(intr, 1'b1);
        lic_host_i.ack(v, vv);
        chk8(v, exp);
        chk1(vv, 1'b1);
    endtask
    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        logic [7:0] d;
        repeat (4) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        lic_host_i.rd(16'h04d0, d);
        chk8(d, 8'h00);
        img(16'h0020, 8'h0a, 8'hff);
        img(16'h0020, 8'h0b, 8'h00);
        img(16'h0020, 8'h08, 8'h00);
        img(16'h0020, 8'h09, 8'h00);
        img(16'h04d0, 8'hff, 8'hfa);
        img(16'h04d1, 8'hff, 8'hde);
        img(16'h04d2, 8'h55, 8'h00);
        img(16'h04d0, 8'h00, 8'h00);
        img(16'h04d1, 8'h00, 8'h00);
        lic_host_i.init(16'h0020, 8'h11, 8'h08, 8'h04, 8'h01);
        lic_host_i.init(16'h00a0, 8'h11, 8'h70, 8'h02, 8'h01);
        // Edge line through pending and in-service
        pins(16'h0020);
        img(16'h0020, 8'h0a, 8'hdf);
        serve(8'h0d);
        img(16'h0020, 8'h0b, 8'h20);
        img(16'h0020, 8'h0a, 8'hff);
        // Priority blocking against the line in service
        pins(16'h0060);
        chk1(intr, 1'b0);
        pins(16'h0068);
        serve(8'h0b);
        img(16'h0020, 8'h0b, 8'h28);
        lic_host_i.wr(16'h0020, 8'h20);
        img(16'h0020, 8'h0b, 8'h20);
        lic_host_i.wr(16'h0020, 8'h65);
        serve(8'h0e);
        img(16'h0020, 8'h0b, 8'h40);
        // Special mask lets a lower line through
        pins(16'h00e8);
        chk1(intr, 1'b0);
        lic_host_i.wr(16'h0020, 8'h68);
        serve(8'h0f);
        lic_host_i.wr(16'h0020, 8'h48);
        lic_host_i.wr(16'h0020, 8'h67);
        lic_host_i.wr(16'h0020, 8'h66);
        img(16'h0020, 8'h0b, 8'h00);
        // Mask register
        pins(16'h0000);
        img(16'h0021, 8'h20, 8'h20);
        pins(16'h0020);
        chk1(intr, 1'b0);
        lic_host_i.wr(16'h0021, 8'h00);
        serve(8'h0d);
        lic_host_i.wr(16'h0020, 8'h20);
        // Slave line through the cascade
        pins(16'h0400);
        serve(8'h72);
        img(16'h00a0, 8'h0b, 8'h04);
        img(16'h0020, 8'h0b, 8'h04);
        lic_host_i.wr(16'h00a0, 8'h62);
        lic_host_i.wr(16'h0020, 8'h62);
        // Set priority, no-op code and rotating ends of service
        lic_host_i.wr(16'h0020, 8'hc4);
        pins(16'h0048);
        serve(8'h0e);
        lic_host_i.wr(16'h0020, 8'h40);
        img(16'h0020, 8'h0b, 8'h40);
        lic_host_i.wr(16'h0020, 8'he6);
        pins(16'h00c8);
        serve(8'h0f);
        lic_host_i.wr(16'h0020, 8'ha0);
        serve(8'h0b);
        lic_host_i.wr(16'h0020, 8'h20);
        img(16'h0020, 8'h0b, 8'h00);
        // Level mode for the whole controller with automatic rotation
        pins(16'h0000);
        lic_host_i.init(16'h0020, 8'h19, 8'h08, 8'h04, 8'h03);
        lic_host_i.wr(16'h0020, 8'h80);
        pins(16'h0008);
        serve(8'h0b);
        img(16'h0020, 8'h0b, 8'h00);
        pins(16'h001a);
        serve(8'h0c);
        img(16'h0020, 8'h0a, 8'he5);
        pins(16'h0000);
        img(16'h0020, 8'h0a, 8'hff);
        end_sim();
    end
endmodule // lic_top_tb_top
`default_nettype wire
